// ---- esx_pkg.sv ----
// Purpose: shared constants and carriers for the extend/select/indexed-store execution block
// Assumes: 64-bit general and floating point registers, 32-bit instruction words
// Notes:   release levels are small integers compared against configuration inputs
package esx_pkg;
	localparam logic [5:0] OP_THIRD_SPECIAL  = 6'h1f; // 011111
	localparam logic [5:0] OP_FPU_GROUP      = 6'h11; // 010001
	localparam logic [5:0] OP_IDX_STORE      = 6'h13; // cop1x major group
	localparam logic [5:0] FN_BIT_SHUFFLE    = 6'h20; // 100000
	localparam logic [5:0] FN_FP_SELECT      = 6'h10; // 010000
	localparam logic [5:0] FN_IDX_DW_STORE   = 6'h09; // indexed doubleword store function
	localparam logic [4:0] SA_BYTE_EXT       = 5'h10; // 10000
	localparam logic [4:0] SA_HALF_EXT       = 5'h18; // 11000
	localparam logic [4:0] FMT_SINGLE        = 5'h10;
	localparam logic [4:0] FMT_DOUBLE        = 5'h11;
	localparam logic [3:0] REL_SIGN_EXT_MIN  = 4'h2;
	localparam logic [3:0] REL_NO_IDX_STORE  = 4'h6;
	localparam logic [3:0] REL_SELECT_MIN    = 4'h6;
	localparam int         DW_ALIGN_BITS     = 3;
	localparam logic [63:0] HI_WORD_ADDR_FLIP = 64'h4; // 0b100

	typedef enum logic [2:0] {
		ESX_EXC_NONE,
		ESX_EXC_RESERVED,
		ESX_EXC_ADDR_ERR,
		ESX_EXC_CP_UNUSABLE,
		ESX_EXC_MEMORY
	} esx_exc_t;

	typedef enum logic [1:0] {
		ESX_MEXC_NONE,
		ESX_MEXC_TLB_REFILL,
		ESX_MEXC_TLB_INVALID,
		ESX_MEXC_TLB_MODIFIED
	} esx_mexc_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic [63:0] gpr_a;   // base or source_gpr_field value
		logic [63:0] gpr_b;   // index
		logic [63:0] fpr_s;   // fp_first_source_reg
		logic [63:0] fpr_t;   // fp_second_source_reg
		logic [63:0] fpr_d;   // fp_destination_reg prior contents
	} esx_req_t;

	typedef struct packed {
		logic        valid;
		logic        gpr_we;
		logic        fpr_we;
		logic [4:0]  dest;
		logic [63:0] data;
		esx_exc_t    exc;
		logic        watch;
	} esx_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
		logic [31:0] data;
		logic        upper;
	} esx_mem_t;
endpackage : esx_pkg

// ---- esx_decode.sv ----
// Purpose: classify an instruction word into the operations this block executes
// Assumes: instruction fields at their standard positions
// Notes:   purely combinational
`timescale 1ns/100ps
module esx_decode (
	input  wire logic [31:0] instr,
	output logic             is_byte_ext,
	output logic             is_half_ext,
	output logic             is_select,
	output logic             select_bad_fmt,
	output logic             select_double,
	output logic             is_idx_store
);
	import esx_pkg::*;
	logic [5:0] op;
	logic [5:0] fn;
	logic [4:0] rs;
	logic [4:0] sa;
	assign op = instr[31:26];
	assign fn = instr[5:0];
	assign rs = instr[25:21];
	assign sa = instr[10:6];
	assign is_byte_ext = op == OP_THIRD_SPECIAL && rs == 5'h00 && sa == SA_BYTE_EXT && fn == FN_BIT_SHUFFLE;
	assign is_half_ext = op == OP_THIRD_SPECIAL && rs == 5'h00 && sa == SA_HALF_EXT && fn == FN_BIT_SHUFFLE;
	// fmt sits in the rs position for the fpu group
	assign is_select = op == OP_FPU_GROUP && fn == FN_FP_SELECT && rs[4];
	assign select_bad_fmt = is_select && rs != FMT_SINGLE && rs != FMT_DOUBLE;
	assign select_double = rs == FMT_DOUBLE;
	assign is_idx_store = op == OP_IDX_STORE && fn == FN_IDX_DW_STORE && sa == 5'h00;
endmodule : esx_decode

// ---- esx_store_split.sv ----
// Purpose: split a doubleword store into two word writes
// Assumes: the address is already doubleword aligned
// Notes:   big-endian xor reverse-endian picks which word goes first in memory
`timescale 1ns/100ps
module esx_store_split (
	input  wire logic [63:0] ea,
	input  wire logic        endian_flip,
	input  wire logic [63:0] dw,
	output logic [63:0]      lo_addr,
	output logic [63:0]      hi_addr,
	output logic [31:0]      lo_data,
	output logic [31:0]      hi_data
);
	import esx_pkg::*;
	assign lo_addr = ea ^ {61'h0, endian_flip, 2'b00};
	assign hi_addr = lo_addr ^ HI_WORD_ADDR_FLIP;
	assign lo_data = dw[31:0];
	assign hi_data = dw[63:32];
endmodule : esx_store_split

// ---- esx_exec.sv ----
// Purpose: execute byte/halfword sign extension, fp select and indexed fp doubleword store
// Assumes: operands arrive read from the register files; memory takes one word per cycle
// Notes:   one instruction in flight; req_ready low while a store is being issued
//
// Operation
// - store address is base plus index, no displacement.
// - misaligned store address raises address error and stores nothing.
// - store writes all 64 bits of the fp source as raw bits.
// - low word at endian-adjusted address, high word with address bit 2 flipped.
// - release 6 configuration treats the indexed store as reserved instruction.
// - indexed store present whenever an fpu exists, either width or mode.
// - indexed store may raise tlb, coprocessor, address, reserved and watch exceptions.
// - byte extend decoded from 011111, rs zero, sa 10000, function 100000.
// - halfword extend decoded from 011111, rs zero, sa 11000, function 100000.
// - byte extend replicates bit 7 into all upper bits.
// - halfword extend replicates bit 15 into all upper bits.
// - before release 2 both extend encodings are reserved instruction.
// - extend result unpredictable unless source bits 63 to 31 agree.
// - select decoded from 010001 with function 010000, single or double.
// - select condition is only bit 0 of old destination value.
// - condition set writes second source, else first source, to destination.
// - single moves 32 bits, double moves 64 bits, any data type.
// - select raises no data exception and leaves fp status unchanged.
// - select exists only from release 6 onward.
// - other select formats raise reserved instruction.
`timescale 1ns/100ps
module esx_exec (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [3:0]          arch_release,
	input  wire logic                fpu_present,
	input  wire logic                fpu_enabled,
	input  wire logic                endian_flip,
	input  wire esx_pkg::esx_req_t   req,
	output logic                     req_ready,
	output esx_pkg::esx_rsp_t        rsp,
	output esx_pkg::esx_mem_t        mem,
	input  wire logic                mem_ready,
	input  wire esx_pkg::esx_mexc_t  mem_exc,
	input  wire logic                mem_watch,
	output logic                     fp_status_we
);
	import esx_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		ESX_IDLE,
		ESX_ST_LO,
		ESX_ST_HI
	} esx_state_t;

	typedef struct packed {
		esx_state_t  state;
		esx_rsp_t    rsp;
		esx_mem_t    mem;
		logic [63:0] hi_addr;
		logic [31:0] hi_data;
	} esx_regs_t;

	esx_regs_t   st_r;
	esx_regs_t   st_nxt;

	logic        is_byte_ext;
	logic        is_half_ext;
	logic        is_select;
	logic        select_bad_fmt;
	logic        select_double;
	logic        is_idx_store;
	logic [63:0] ea;
	logic [63:0] lo_addr;
	logic [63:0] hi_addr;
	logic [31:0] lo_data;
	logic [31:0] hi_data;
	logic [63:0] sel_val;

	////////////////////////////////////////////////////////////////////////
	esx_decode u_decode (
		.instr          (req.instr),
		.is_byte_ext    (is_byte_ext),
		.is_half_ext    (is_half_ext),
		.is_select      (is_select),
		.select_bad_fmt (select_bad_fmt),
		.select_double  (select_double),
		.is_idx_store   (is_idx_store)
	);

	assign ea = req.gpr_a + req.gpr_b;

	esx_store_split u_split (
		.ea          (ea),
		.endian_flip (endian_flip),
		.dw          (req.fpr_s),
		.lo_addr     (lo_addr),
		.hi_addr     (hi_addr),
		.lo_data     (lo_data),
		.hi_data     (hi_data)
	);

	// only bit 0 of the old destination matters
	assign sel_val = req.fpr_d[0] ? req.fpr_t : req.fpr_s;

	// the select never touches the fp status register
	assign fp_status_we = 1'b0;

	assign req_ready = st_r.state == ESX_IDLE;
	assign rsp = st_r.rsp;
	assign mem = st_r.mem;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.valid = 1'b0;
		st_nxt.rsp.watch = 1'b0;
		case (st_r.state)
			ESX_IDLE: begin
				st_nxt.mem.valid = 1'b0;
				if (req.valid) begin
					st_nxt.rsp.valid = 1'b1;
					st_nxt.rsp.gpr_we = 1'b0;
					st_nxt.rsp.fpr_we = 1'b0;
					st_nxt.rsp.exc = ESX_EXC_NONE;
					st_nxt.rsp.data = 64'h0;
					st_nxt.rsp.dest = req.instr[15:11];
					if (is_byte_ext || is_half_ext) begin
						// result for non-word sources is unpredictable; no check is made
						if (arch_release < REL_SIGN_EXT_MIN) begin
							st_nxt.rsp.exc = ESX_EXC_RESERVED;
						end else begin
							st_nxt.rsp.gpr_we = 1'b1;
							if (is_byte_ext) begin
								st_nxt.rsp.data = {{56{req.gpr_a[7]}}, req.gpr_a[7:0]};
							end else begin
								st_nxt.rsp.data = {{48{req.gpr_a[15]}}, req.gpr_a[15:0]};
							end
						end
					end else if (is_select) begin
						st_nxt.rsp.dest = req.instr[10:6];
						if (!fpu_present || !fpu_enabled) begin
							st_nxt.rsp.exc = ESX_EXC_CP_UNUSABLE;
						end else if (arch_release < REL_SELECT_MIN || select_bad_fmt) begin
							st_nxt.rsp.exc = ESX_EXC_RESERVED;
						end else begin
							st_nxt.rsp.fpr_we = 1'b1;
							// upper half of a single result is left zero
							st_nxt.rsp.data = select_double ? sel_val : {32'h0, sel_val[31:0]};
						end
					end else if (is_idx_store) begin
						st_nxt.rsp.dest = 5'h00;
						if (arch_release >= REL_NO_IDX_STORE) begin
							st_nxt.rsp.exc = ESX_EXC_RESERVED;
						end else if (!fpu_present || !fpu_enabled) begin
							st_nxt.rsp.exc = ESX_EXC_CP_UNUSABLE;
						end else if (ea[DW_ALIGN_BITS-1:0] != 3'b000) begin
							st_nxt.rsp.exc = ESX_EXC_ADDR_ERR;
						end else begin
							// answer waits until the high word is accepted, or until memory reports a fault or watch hit
							st_nxt.rsp.valid = 1'b0;
							st_nxt.mem.valid = 1'b1;
							st_nxt.mem.addr = lo_addr;
							st_nxt.mem.data = lo_data;
							st_nxt.mem.upper = 1'b0;
							st_nxt.hi_addr = hi_addr;
							st_nxt.hi_data = hi_data;
							st_nxt.state = ESX_ST_LO;
						end
					end else begin
						st_nxt.rsp.exc = ESX_EXC_RESERVED;
					end
				end
			end
			ESX_ST_LO: begin
				if (mem_exc != ESX_MEXC_NONE || mem_watch) begin
					st_nxt.mem.valid = 1'b0;
					st_nxt.rsp.valid = 1'b1;
					st_nxt.rsp.exc = mem_exc != ESX_MEXC_NONE ? ESX_EXC_MEMORY : ESX_EXC_NONE;
					st_nxt.rsp.watch = mem_watch;
					st_nxt.state = ESX_IDLE;
				end else if (mem_ready) begin
					st_nxt.mem.addr = st_r.hi_addr;
					st_nxt.mem.data = st_r.hi_data;
					st_nxt.mem.upper = 1'b1;
					st_nxt.state = ESX_ST_HI;
				end
			end
			ESX_ST_HI: begin
				if (mem_exc != ESX_MEXC_NONE || mem_watch || mem_ready) begin
					st_nxt.mem.valid = 1'b0;
					st_nxt.rsp.valid = 1'b1;
					st_nxt.rsp.exc = mem_exc != ESX_MEXC_NONE ? ESX_EXC_MEMORY : ESX_EXC_NONE;
					st_nxt.rsp.watch = mem_watch;
					st_nxt.state = ESX_IDLE;
				end
			end
			default: begin
				st_nxt.state = ESX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : esx_exec

// ---- esx_chk_sva.sv ----
// Purpose: port-level checks of the execution block
// Assumes: one clock, synchronous active-high reset
// Notes:   extend results judged only for word-valid sources
`timescale 1ns/100ps
module esx_chk (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic [3:0]         arch_release,
	input wire logic               fpu_present,
	input wire logic               fpu_enabled,
	input wire logic               endian_flip,
	input wire esx_pkg::esx_req_t  req,
	input wire logic               req_ready,
	input wire esx_pkg::esx_rsp_t  rsp,
	input wire esx_pkg::esx_mem_t  mem,
	input wire logic               mem_ready,
	input wire esx_pkg::esx_mexc_t mem_exc,
	input wire logic               mem_watch,
	input wire logic               fp_status_we
);
	import esx_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	wire logic [31:0] ins = req.instr;
	wire logic take = req.valid && req_ready;
	wire logic fpu_ok = fpu_present && fpu_enabled;
	wire logic ext_enc = ins[31:21] == {OP_THIRD_SPECIAL, 5'h0} && ins[5:0] == FN_BIT_SHUFFLE;
	wire logic ext_go = take && ext_enc && arch_release >= REL_SIGN_EXT_MIN &&
		(&req.gpr_a[63:31] || ~|req.gpr_a[63:31]);
	wire logic st_enc = take && fpu_ok && ins[31:26] == OP_IDX_STORE && ins[5:0] == FN_IDX_DW_STORE &&
		ins[10:6] == 5'h00;
	wire logic st_go = st_enc && arch_release < REL_NO_IDX_STORE;
	wire logic [63:0] ea = req.gpr_a + req.gpr_b;
	wire logic no_exc = mem_exc == ESX_MEXC_NONE && !mem_watch;
	sequence s_lo_taken; mem.valid && !mem.upper && mem_ready && no_exc; endsequence
	sequence s_hi_taken; mem.valid && mem.upper && mem_ready && no_exc; endsequence
	sequence s_hi_word; mem.valid && mem.upper && mem.addr == ($past(mem.addr) ^ HI_WORD_ADDR_FLIP); endsequence
	////////////////////////////////////////
	a_lo_word_addr: assert property (st_go && ea[2:0] == 3'h0 |=> mem.valid && !mem.upper &&
		mem.addr == ($past(ea) ^ 64'({$past(endian_flip), 2'b00})) && mem.data == $past(req.fpr_s[31:0]))
		else $error("low store word wrong");
	a_hi_word_addr: assert property (s_lo_taken |=> s_hi_word) else $error("high store word wrong");
	a_store_done: assert property (s_hi_taken |=> rsp.valid && rsp.exc == ESX_EXC_NONE && !mem.valid)
		else $error("store did not finish");
	a_word_hold: assert property (mem.valid && !mem_ready && no_exc |=> mem.valid && $stable(mem.addr) &&
		$stable(mem.data)) else $error("store word not held");
	a_misalign_error: assert property (st_go && ea[2:0] != 3'h0 |=> rsp.valid &&
		rsp.exc == ESX_EXC_ADDR_ERR && !mem.valid) else $error("misaligned store not refused");
	a_store_reserved: assert property (st_enc && arch_release >= REL_NO_IDX_STORE |=> rsp.valid &&
		rsp.exc == ESX_EXC_RESERVED && !mem.valid) else $error("store at new release not reserved");
	a_byte_extend: assert property (ext_go && ins[10:6] == SA_BYTE_EXT |=> rsp.valid && rsp.gpr_we &&
		rsp.data == {{56{$past(req.gpr_a[7])}}, $past(req.gpr_a[7:0])}) else $error("byte extend wrong");
	a_half_extend: assert property (ext_go && ins[10:6] == SA_HALF_EXT |=> rsp.valid && rsp.gpr_we &&
		rsp.data == {{48{$past(req.gpr_a[15])}}, $past(req.gpr_a[15:0])}) else $error("halfword extend wrong");
	a_old_extend: assert property (take && ext_enc && arch_release < REL_SIGN_EXT_MIN |=> rsp.valid &&
		rsp.exc == ESX_EXC_RESERVED && !rsp.gpr_we) else $error("old release extend not reserved");
	a_select_pick: assert property (take && fpu_ok && arch_release >= REL_SELECT_MIN &&
		ins[31:21] == {OP_FPU_GROUP, FMT_DOUBLE} && ins[5:0] == FN_FP_SELECT |=> rsp.fpr_we &&
		rsp.data == ($past(req.fpr_d[0]) ? $past(req.fpr_t) : $past(req.fpr_s))) else $error("select wrong");
	a_status_quiet: assert property (!fp_status_we) else $error("fp status written");
	a_result_no_mem: assert property (rsp.valid && rsp.gpr_we |-> !mem.valid) else $error("extend touched memory");
endmodule : esx_chk
bind esx_exec esx_chk u_chk (.clk, .reset, .arch_release, .fpu_present, .fpu_enabled, .endian_flip, .req,
	.req_ready, .rsp, .mem, .mem_ready, .mem_exc, .mem_watch, .fp_status_we);

// ---- esx_mem_model.sv ----
// Purpose: memory side of the store path
// Assumes: one word accepted per ready pulse
// Notes:   fault 1 gives a tlb refill, 2 a watch hit
`timescale 1ns/100ps
module esx_mem_model (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire esx_pkg::esx_mem_t mem,
	input  wire logic [3:0]        stall,
	input  wire logic [1:0]        fault,
	output logic                   mem_ready,
	output esx_pkg::esx_mexc_t     mem_exc,
	output logic                   mem_watch
);
	import esx_pkg::*;
	logic [3:0] wait_r;
	////////////////////////////////////////
	// ready drops after each accept, so every word waits at least one cycle
	always @(posedge clk) begin
		if (reset || !mem.valid || mem_ready) begin
			wait_r <= 4'h0;
			mem_ready <= 1'b0;
		end else begin
			wait_r <= wait_r + 4'h1;
			mem_ready <= wait_r >= stall;
		end
	end
	assign mem_exc = mem.valid && fault == 2'h1 ? ESX_MEXC_TLB_REFILL : ESX_MEXC_NONE;
	assign mem_watch = mem.valid && fault == 2'h2;
endmodule : esx_mem_model

// ---- extend_select_indexed_store_exec_tb_top.sv ----
// Purpose: self-checking bench for the execution block
// Assumes: memory side played by esx_mem_model
// Notes:   one request in flight; each task waits for its response
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module extend_select_indexed_store_exec_tb_top;
	import esx_pkg::*;
	localparam logic [31:0] st_instr = {OP_IDX_STORE, 5'h1, 5'h2, 5'h4, 5'h0, FN_IDX_DW_STORE};
	logic       clk = 0, reset = 1, fpu_present = 1, fpu_enabled = 1, endian_flip = 0;
	logic       req_ready, mem_ready, mem_watch, fp_status_we;
	logic [3:0] arch_release = 4'h2, stall = 4'h0;
	logic [1:0] fault = 2'h0;
	esx_req_t   req = '0;
	esx_rsp_t   rsp, got;
	esx_mem_t   mem;
	esx_mexc_t  mem_exc;
	logic [63:0] wa [2];
	logic [31:0] wd [2];
	int         n_mismatch = 0, n_compared = 0, nw = 0;
	always #4 clk = ~clk;
	esx_exec uut (.clk, .reset, .arch_release, .fpu_present, .fpu_enabled, .endian_flip, .req, .req_ready, .rsp,
		.mem, .mem_ready, .mem_exc, .mem_watch, .fp_status_we);
	esx_mem_model u_mem (.clk, .reset, .mem, .stall, .fault, .mem_ready, .mem_exc, .mem_watch);
	// word count restarts at each accepted request; only this process writes it
	always @(posedge clk) begin
		if (req.valid && req_ready) begin
			nw <= 0;
		end else if (mem.valid && mem_ready) begin
			wa[nw[0]] <= mem.addr;
			wd[nw[0]] <= mem.data;
			nw <= nw + 1;
		end
	end
	////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic run(input logic [31:0] i, input logic [63:0] a = 64'h0, b = 64'h0, s = 64'h0, t = 64'h0,
		d = 64'h0);
		int k;
		req <= '{1'b1, i, a, b, s, t, d};
		@(posedge clk);
		#1 req.valid <= 1'b0;
		for (k = 0; k < 50 && rsp.valid !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 50) begin
			n_mismatch++;
			tally_and_finish;
		end
		got = rsp;
		@(posedge clk);
		#1;
	endtask : run
	function automatic logic [31:0] ext(input logic [4:0] sa);
		return {OP_THIRD_SPECIAL, 5'h0, 5'h3, 5'h9, sa, FN_BIT_SHUFFLE};
	endfunction : ext
	////////////////////////////////////////
	task automatic t_extend;
		logic [63:0] v [4] = '{64'h80, 64'h7f, 64'h8000, 64'hffff_ffff_8000_7f7f};
		for (int n = 0; n < 4; n++) begin
			run(ext(SA_BYTE_EXT), v[n]);
			`CHK(got.data, {{56{v[n][7]}}, v[n][7:0]})
			`CHK({got.gpr_we, got.dest, got.exc, nw[1:0]}, {1'b1, 5'h9, ESX_EXC_NONE, 2'h0})
			run(ext(SA_HALF_EXT), v[n]);
			`CHK(got.data, {{48{v[n][15]}}, v[n][15:0]})
		end
		arch_release = 4'h1;
		run(ext(SA_HALF_EXT), 64'h80);
		`CHK({got.gpr_we, got.exc}, {1'b0, ESX_EXC_RESERVED})
	endtask : t_extend
	task automatic t_select;
		logic [63:0] s = 64'h7ff0_0000_0000_0001, t = 64'hfff8_0000_1234_5678, e, m;
		arch_release = 4'h6;
		for (int n = 0; n < 4; n++) begin
			m = n[1] ? '1 : 64'hffff_ffff;
			e = n[0] ? t : s;
			run({OP_FPU_GROUP, n[1] ? FMT_DOUBLE : FMT_SINGLE, 15'h0c5, FN_FP_SELECT}, .s(s), .t(t), .d({63'h5, n[0]}));
			`CHK(got.data & m, e & m)
			`CHK({got.fpr_we, got.exc, got.dest}, {1'b1, ESX_EXC_NONE, 5'h5})
		end
		for (int n = 0; n < 2; n++) begin
			arch_release = n ? 4'h5 : 4'h6;
			run({OP_FPU_GROUP, n ? FMT_DOUBLE : 5'h14, 15'h0c5, FN_FP_SELECT});
			`CHK({got.fpr_we, got.exc}, {1'b0, ESX_EXC_RESERVED})
		end
	endtask : t_select
	task automatic t_store;
		logic [63:0] s = 64'h89ab_cdef_0123_4567, ea;
		esx_exc_t ex [5] = '{ESX_EXC_ADDR_ERR, ESX_EXC_RESERVED, ESX_EXC_MEMORY, ESX_EXC_NONE, ESX_EXC_CP_UNUSABLE};
		arch_release = 4'h2;
		for (int n = 0; n < 4; n++) begin
			endian_flip = n[0];
			stall = n[1] ? 4'h3 : 4'h0;
			ea = 64'h1000_1008 ^ 64'({n[0], 2'b00});
			run(st_instr, 64'h1000_0ff0, 64'h18, s);
			`CHK({wa[0], wd[0], nw[1:0]}, {ea, s[31:0], 2'h2})
			`CHK({wa[1], wd[1], got.exc}, {ea ^ HI_WORD_ADDR_FLIP, s[63:32], ESX_EXC_NONE})
		end
		for (int n = 0; n < 5; n++) begin
			arch_release = n == 1 ? 4'h6 : 4'h2;
			fault = n == 2 ? 2'h1 : n == 3 ? 2'h2 : 2'h0;
			fpu_enabled = n != 4;
			run(st_instr, n == 0 ? 64'h4 : 64'h0, 64'h18, s);
			`CHK({got.exc, got.watch, nw[1:0]}, {ex[n], n == 3, 2'h0})
		end
	endtask : t_store
	initial begin
		repeat (5) @(posedge clk);
		#1 reset = 0;
		t_extend;
		t_select;
		t_store;
		tally_and_finish;
	end
endmodule : extend_select_indexed_store_exec_tb_top
